// ### src/trace_count_defines.vh
// Register map, field positions and reset values of the trace counter block.
`ifndef TRACE_COUNT_DEFINES_VH
`define TRACE_COUNT_DEFINES_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define IDX_DEBUG_CONTROL_ONE 8'h20
`define IDX_DEBUG_STATUS 8'h21
`define IDX_TRACE_COUNT 8'h26
`define IDX_BANKED_STATE 8'h27
`define IDX_COMPARATOR_CONTROL 8'h28
`define IDX_LSB_PAD 2'b00

// ****************************************************************
// Field positions.
// ****************************************************************
`define CTL_ARM_BIT 7
`define CTL_ALIGN_BIT 4
`define CTL_BANK_HI 1
`define CTL_BANK_LO 0
`define STATUS_FULL_BIT 7
`define COUNT_FULL_BIT 7
`define SC_HI 3
`define SC_LO 0

// ****************************************************************
// Bank view codes for the shared state control address.
// ****************************************************************
`define BANK_STATE1 2'h0
`define BANK_STATE2 2'h1
`define BANK_STATE3 2'h2
`define BANK_MATCH_FLAGS 2'h3

// ****************************************************************
// Sequencer state codes as reported in the status register.
// ****************************************************************
`define SEQ_CODE_DISARMED 3'h0
`define SEQ_CODE_STATE1 3'h1
`define SEQ_CODE_STATE2 3'h2
`define SEQ_CODE_STATE3 3'h3
`define SEQ_CODE_FINAL 3'h4

// ****************************************************************
// Per-channel targets decoded from a next-state code.
// ****************************************************************
`define TGT_NONE 2'h0
`define TGT_STATE2 2'h1
`define TGT_STATE3 2'h2
`define TGT_FINAL 2'h3

// ****************************************************************
// Reset values and counter constants.
// ****************************************************************
`define RST_BYTE 8'h00
`define RST_COUNT 6'h00
`define RST_CODE 4'h0
`define RST_BANK 2'h0
`define RST_FLAGS 3'h0
`define COUNT_ONE 6'h01
`define COUNT_LAST 6'h3f

`endif

// ### src/trace_count_state1_sequencer.v
// Trace line counter, full flag and State1 sequencer control with APB access.
`timescale 1ns/1ps
`default_nettype none
`include "trace_count_defines.vh"

module trace_count_state1_sequencer #(
    parameter ADDR_W = 10,
    parameter MATCH_N = 3
) (
    // Clock and power-on reset.
    input wire core_clk,
    input wire rst_b,
    // Other system reset, keeps count and full flag.
    input wire sys_rst_req,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Trace buffer and comparators.
    input wire trace_line_wr,
    input wire [MATCH_N-1:0] match_in,
    // Status.
    output reg armed,
    output reg [4:0] seq_state,
    output reg trace_full_flag,
    output reg [5:0] trace_line_count
);

    // ****************************************************************
    // Sequencer states.
    // ****************************************************************
    localparam [4:0] ST_DISARMED = 5'b00001;
    localparam [4:0] ST_STATE1 = 5'b00010;
    localparam [4:0] ST_STATE2 = 5'b00100;
    localparam [4:0] ST_STATE3 = 5'b01000;
    localparam [4:0] ST_FINAL = 5'b10000;

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    wire [ADDR_W-1:0] a_ctl;
    wire [ADDR_W-1:0] a_stat;
    wire [ADDR_W-1:0] a_cnt;
    wire [ADDR_W-1:0] a_bank;
    wire [ADDR_W-1:0] a_cmp;
    assign a_ctl = {`IDX_DEBUG_CONTROL_ONE, `IDX_LSB_PAD};
    assign a_stat = {`IDX_DEBUG_STATUS, `IDX_LSB_PAD};
    assign a_cnt = {`IDX_TRACE_COUNT, `IDX_LSB_PAD};
    assign a_bank = {`IDX_BANKED_STATE, `IDX_LSB_PAD};
    assign a_cmp = {`IDX_COMPARATOR_CONTROL, `IDX_LSB_PAD};

    reg align_r;
    reg [1:0] bank_r;
    reg [3:0] sc1_r;
    reg [MATCH_N-1:0] cmp_en_r;
    reg [MATCH_N-1:0] mflag_r;

    wire setup;
    wire wr_now;
    wire wr_ctl;
    wire wr_sc1;
    wire wr_cmp;
    wire arm_set;
    wire arm_clr;
    assign setup = psel & ~penable;
    // The write lands only at the edge that also completes the access,
    // and a system reset in that cycle swallows it, so an arming write
    // cannot clear the count while the reset keeps the session disarmed.
    assign wr_now = psel & penable & pready & pwrite & ~sys_rst_req;
    assign wr_ctl = wr_now & (paddr == a_ctl);
    assign wr_sc1 = wr_now & (paddr == a_bank) &
        (bank_r == `BANK_STATE1) & ~armed;
    assign wr_cmp = wr_now & (paddr == a_cmp) & ~armed;
    assign arm_set = wr_ctl & pwdata[`CTL_ARM_BIT];
    assign arm_clr = wr_ctl & ~pwdata[`CTL_ARM_BIT];

    // ****************************************************************
    // Read mux.
    // ****************************************************************
    reg [7:0] rd_byte;
    reg rd_err;
    reg [2:0] st_code;

    always @* begin
        case (seq_state)
            ST_STATE1: st_code = `SEQ_CODE_STATE1;
            ST_STATE2: st_code = `SEQ_CODE_STATE2;
            ST_STATE3: st_code = `SEQ_CODE_STATE3;
            ST_FINAL: st_code = `SEQ_CODE_FINAL;
            default: st_code = `SEQ_CODE_DISARMED;
        endcase
    end

    always @* begin
        rd_byte = `RST_BYTE;
        rd_err = 1'b0;
        if (paddr == a_ctl) begin
            rd_byte[`CTL_ARM_BIT] = armed;
            rd_byte[`CTL_ALIGN_BIT] = align_r;
            rd_byte[`CTL_BANK_HI:`CTL_BANK_LO] = bank_r;
        end else if (paddr == a_stat) begin
            rd_byte[`STATUS_FULL_BIT] = trace_full_flag;
            rd_byte[2:0] = st_code;
        end else if (paddr == a_cnt) begin
            rd_byte[`COUNT_FULL_BIT] = trace_full_flag;
            rd_byte[5:0] = trace_line_count;
        end else if (paddr == a_bank) begin
            // State2/State3 control live elsewhere and read zero here.
            if (bank_r == `BANK_STATE1) begin
                rd_byte[`SC_HI:`SC_LO] = sc1_r;
            end else if (bank_r == `BANK_MATCH_FLAGS) begin
                rd_byte[MATCH_N-1:0] = mflag_r;
            end
        end else if (paddr == a_cmp) begin
            rd_byte[MATCH_N-1:0] = cmp_en_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ****************************************************************
    // APB answer: one access cycle, no wait state.
    // ****************************************************************
    // Read data is captured in the setup cycle, so prdata shows the
    // register as it stood one edge before pready is raised.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & rd_err;
            if (setup & ~pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Control registers, cleared by any reset.
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_b || sys_rst_req) begin
            align_r <= 1'b0;
            bank_r <= `RST_BANK;
            sc1_r <= `RST_CODE;
            cmp_en_r <= `RST_FLAGS;
        end else begin
            if (wr_ctl) begin
                // Bank view stays writable while armed, so the match flags
                // can be looked at in the middle of a session.
                bank_r <= pwdata[`CTL_BANK_HI:`CTL_BANK_LO];
                // Alignment is frozen while a session runs.
                if (!armed) begin
                    align_r <= pwdata[`CTL_ALIGN_BIT];
                end
            end
            if (wr_sc1) begin
                sc1_r <= pwdata[`SC_HI:`SC_LO];
            end
            if (wr_cmp) begin
                cmp_en_r <= pwdata[MATCH_N-1:0];
            end
        end
    end

    // ****************************************************************
    // State1 next-state decode.
    // ****************************************************************
    wire [MATCH_N-1:0] mt;
    assign mt = match_in & cmp_en_r;

    reg [1:0] t0;
    reg [1:0] t1;
    reg [1:0] t2;

    always @* begin
        t0 = `TGT_NONE;
        t1 = `TGT_NONE;
        t2 = `TGT_NONE;
        case (sc1_r)
            4'h0: begin
                t0 = `TGT_FINAL;
                t1 = `TGT_FINAL;
                t2 = `TGT_FINAL;
            end
            4'h1: t1 = `TGT_STATE3;
            4'h2: t2 = `TGT_STATE2;
            4'h3: t1 = `TGT_STATE2;
            4'h4: begin
                t0 = `TGT_STATE2;
                t1 = `TGT_STATE3;
            end
            4'h5: begin
                t0 = `TGT_FINAL;
                t1 = `TGT_STATE3;
            end
            4'h6: begin
                t0 = `TGT_STATE2;
                t2 = `TGT_STATE3;
            end
            4'h7: begin
                t0 = `TGT_STATE2;
                t1 = `TGT_STATE2;
            end
            4'h9: t0 = `TGT_STATE3;
            4'hd: begin
                t0 = `TGT_FINAL;
                t1 = `TGT_STATE2;
                t2 = `TGT_FINAL;
            end
            // Reserved codes name no channel, so nothing moves.
            default: t0 = `TGT_NONE;
        endcase
    end

    // Final beats everything, then the lowest live channel decides.
    reg [1:0] s1_tgt;
    always @* begin
        if ((mt[0] && t0 == `TGT_FINAL) || (mt[1] && t1 == `TGT_FINAL) ||
            (mt[2] && t2 == `TGT_FINAL)) begin
            s1_tgt = `TGT_FINAL;
        end else if (mt[0] && t0 != `TGT_NONE) begin
            s1_tgt = t0;
        end else if (mt[1] && t1 != `TGT_NONE) begin
            s1_tgt = t1;
        end else if (mt[2] && t2 != `TGT_NONE) begin
            s1_tgt = t2;
        end else begin
            s1_tgt = `TGT_NONE;
        end
    end

    // ****************************************************************
    // Line counter and full flag, cleared only by POR and arming.
    // ****************************************************************
    wire store_ok;
    wire line_inc;
    wire wrap;
    wire begin_end;
    // Begin-trigger stores only after the trigger, end-trigger from arming.
    assign store_ok = align_r ? (seq_state == ST_FINAL) : 1'b1;
    assign line_inc = armed & trace_line_wr & store_ok;
    assign wrap = line_inc & (trace_line_count == `COUNT_LAST);
    // Full with a zero count under begin-trigger closes the session.
    assign begin_end = armed & align_r & trace_full_flag &
        (trace_line_count == `RST_COUNT);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            trace_line_count <= `RST_COUNT;
            trace_full_flag <= 1'b0;
        end else if (arm_set) begin
            trace_line_count <= `RST_COUNT;
            trace_full_flag <= 1'b0;
        end else begin
            // Buffer reads have no path into the counter, so reading the
            // trace back never lowers the count.
            if (line_inc) begin
                trace_line_count <= trace_line_count + `COUNT_ONE;
            end
            if (wrap) begin
                trace_full_flag <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Arm state, sequencer and match flags.
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_b || sys_rst_req) begin
            armed <= 1'b0;
            seq_state <= ST_DISARMED;
            mflag_r <= `RST_FLAGS;
        end else begin
            // A match during a re-arm still sets its flag: the set wins
            // over the clear that the arming write brings.
            mflag_r <= (arm_set ? `RST_FLAGS : mflag_r) |
                (armed ? mt : `RST_FLAGS);
            if (arm_set) begin
                armed <= 1'b1;
                seq_state <= ST_STATE1;
            end else if (arm_clr || begin_end || (wrap && align_r)) begin
                // The wrap under begin-trigger ends the session.
                armed <= 1'b0;
                seq_state <= ST_DISARMED;
            end else begin
                case (seq_state)
                    ST_STATE1: begin
                        case (s1_tgt)
                            `TGT_STATE2: seq_state <= ST_STATE2;
                            `TGT_STATE3: seq_state <= ST_STATE3;
                            `TGT_FINAL: seq_state <= ST_FINAL;
                            default: seq_state <= ST_STATE1;
                        endcase
                    end
                    // Apart from a disarm or a re-arm, State2/State3 hold here; no logic in this block moves them on.
                    ST_STATE2: seq_state <= ST_STATE2;
                    ST_STATE3: seq_state <= ST_STATE3;
                    ST_FINAL: seq_state <= ST_FINAL;
                    default: seq_state <= ST_DISARMED;
                endcase
            end
        end
    end

    // A full flag with a nonzero count means all lines are valid and the
    // oldest were overwritten; software reads that from the two fields,
    // so no extra state is kept for it.

endmodule // trace_count_state1_sequencer

`default_nettype wire

// ### verification/test_trace_count_state1_sequencer.sv
// Self-checking bench for the trace counter and State1 sequencer block.
`timescale 1ns/1ps
`default_nettype none
module test_trace_count_state1_sequencer;
    logic core_clk = 1'b0, rst_b = 1'b0, sys_rst_req = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trace_line_wr = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] match_in = 3'h0, en, e;
    logic pready, pslverr, er, armed, full;
    logic [4:0] seq_state;
    logic [5:0] cnt;
    logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
        4'h7, 4'h9, 4'hd};
    int n_mismatch = 0, compares = 0, cyc = 0, m;

    trace_count_state1_sequencer u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .sys_rst_req(sys_rst_req), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trace_line_wr(trace_line_wr),
        .match_in(match_in), .armed(armed), .seq_state(seq_state),
        .trace_full_flag(full), .trace_line_count(cnt));

    always #5 core_clk = ~core_clk;

    // ****************************************************************
    // Reference model and shared tasks.
    // ****************************************************************
    // Target per channel, one nibble each: 2 State2, 3 State3, 4 Final.
    function automatic logic [2:0] nxt(input logic [3:0] c,
        input logic [2:0] mt);
        logic [11:0] t;
        logic [2:0] r;
        case (c)
            4'h0: t = 12'h444;
            4'h1: t = 12'h030;
            4'h2: t = 12'h200;
            4'h3: t = 12'h020;
            4'h4: t = 12'h032;
            4'h5: t = 12'h034;
            4'h6: t = 12'h302;
            4'h7: t = 12'h022;
            4'h9: t = 12'h003;
            4'hd: t = 12'h424;
            default: t = 12'h000;
        endcase
        r = 3'h1;
        for (int i = 2; i >= 0; i--) if (mt[i] && t[4*i+:3] != 3'h0) r = t[4*i+:3];
        for (int i = 0; i < 3; i++) if (mt[i] && t[4*i+:3] == 3'h4) r = 3'h4;
        return r;
    endfunction

    function automatic logic [31:0] cnt_exp(input int n);
        return {24'h0, n >= 64, 1'b0, n[5:0]};
    endfunction

    task complete_run;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // The extra edge lets the last count update land before a check.
    task lines(input int n);
        repeat (n) begin
            @(posedge core_clk);
            trace_line_wr <= 1'b1;
            @(posedge core_clk);
            trace_line_wr <= 1'b0;
        end
        @(posedge core_clk);
    endtask

    task pulse_match(input logic [2:0] v);
        @(posedge core_clk);
        match_in <= v;
        @(posedge core_clk);
        match_in <= 3'h0;
        repeat (2) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run;
        end
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        void'($urandom(92));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(1'b0, 10'h098, 32'h0);
        chk(rd, cnt_exp(0));
        apb(1'b0, 10'h084, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 10'h03c, 32'h0);
        chk(er, 32'h1);
        foreach (codes[k]) for (m = 1; m < 8; m++) begin
            apb(1'b1, 10'h080, 32'h0);
            apb(1'b1, 10'h09c, {28'h0, codes[k]});
            en = 3'($urandom);
            apb(1'b1, 10'h0a0, {29'h0, en});
            apb(1'b1, 10'h080, 32'h80);
            pulse_match(m[2:0]);
            e = nxt(codes[k], m[2:0] & en);
            chk(seq_state, 5'h01 << e);
            apb(1'b0, 10'h084, 32'h0);
            chk(rd, {29'h0, e});
        end
        apb(1'b1, 10'h09c, 32'h5);
        apb(1'b0, 10'h09c, 32'h0);
        chk(rd, 32'hd);
        apb(1'b1, 10'h080, 32'h1);
        apb(1'b1, 10'h09c, 32'h5);
        apb(1'b0, 10'h09c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 10'h080, 32'h2);
        apb(1'b0, 10'h09c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 10'h080, 32'h3);
        apb(1'b0, 10'h09c, 32'h0);
        chk(rd, {29'h0, en});
        apb(1'b1, 10'h080, 32'h0);
        apb(1'b0, 10'h09c, 32'h0);
        chk(rd, 32'hd);
        apb(1'b1, 10'h080, 32'h80);
        lines(5);
        apb(1'b0, 10'h098, 32'h0);
        chk(rd, cnt_exp(5));
        apb(1'b1, 10'h098, 32'h3f);
        @(posedge core_clk);
        chk(cnt, 6'h05);
        lines(65);
        apb(1'b0, 10'h098, 32'h0);
        chk(rd, cnt_exp(70));
        apb(1'b0, 10'h084, 32'h0);
        chk(rd, 32'h81);
        @(posedge core_clk);
        sys_rst_req <= 1'b1;
        @(posedge core_clk);
        sys_rst_req <= 1'b0;
        @(posedge core_clk);
        chk({armed, full, cnt}, {2'b01, 6'h06});
        apb(1'b1, 10'h080, 32'h80);
        @(posedge core_clk);
        chk({full, cnt}, 7'h00);
        apb(1'b1, 10'h080, 32'h0);
        apb(1'b1, 10'h080, 32'h10);
        apb(1'b1, 10'h09c, 32'h0);
        apb(1'b1, 10'h0a0, 32'h1);
        apb(1'b1, 10'h080, 32'h90);
        lines(3);
        chk(cnt, 6'h00);
        pulse_match(3'h1);
        chk(seq_state, 5'h10);
        lines(64);
        @(posedge core_clk);
        chk({armed, full, cnt}, {2'b01, 6'h00});
        lines(2);
        chk(cnt, 6'h00);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk({full, cnt, seq_state}, {7'h00, 5'h01});
        complete_run;
    end
endmodule // test_trace_count_state1_sequencer
`default_nettype wire

// ### verification/trace_count_state1_sequencer_properties.sv
// Concurrent checks on the ports of the trace counter and State1 block.
`timescale 1ns/1ps
`default_nettype none
module trace_count_properties #(
    parameter ADDR_W = 10,
    parameter MATCH_N = 3
) (
    // Clock and resets.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sys_rst_req,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Trace, matches and status.
    input wire logic trace_line_wr,
    input wire logic [MATCH_N-1:0] match_in,
    input wire logic armed,
    input wire logic [4:0] seq_state,
    input wire logic trace_full_flag,
    input wire logic [5:0] trace_line_count
);
    wire ctl_wr = psel && penable && pready && pwrite && paddr == 10'h080;
    wire arm_wr = ctl_wr && pwdata[7];
    wire rd_acc = psel && penable && pready && !pwrite;
    wire mapped = paddr inside {10'h080, 10'h084, 10'h098, 10'h09c, 10'h0a0};

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_arm_clears: assert property (arm_wr && !sys_rst_req |=> armed &&
        trace_line_count == 6'h00 && !trace_full_flag && seq_state == 5'h02)
        else $error("arming did not restart the session");
    a_wrap_full: assert property (armed && trace_line_wr &&
        trace_line_count == 6'h3f && !arm_wr && !sys_rst_req
        |=> trace_full_flag && trace_line_count == 6'h00)
        else $error("count wrap did not set the full flag");
    a_count_hold: assert property (!trace_line_wr && !arm_wr
        |=> $stable(trace_line_count)) else $error("count moved without a line");
    a_count_step: assert property (trace_line_wr && !arm_wr |=>
        $stable(trace_line_count) ||
        trace_line_count == $past(trace_line_count) + 6'h01)
        else $error("count moved by more than one");
    a_sysrst_keep: assert property (sys_rst_req && !trace_line_wr
        |=> $stable(trace_line_count) && $stable(trace_full_flag) && !armed)
        else $error("system reset disturbed count or full flag");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready was not a one-cycle answer");
    a_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match the address map");
    a_status_full: assert property (rd_acc && paddr == 10'h084
        |-> prdata[7] == $past(trace_full_flag))
        else $error("status full bit wrong");
    a_count_read: assert property (rd_acc && paddr == 10'h098 |->
        prdata == {24'h0, $past(trace_full_flag), 1'b0,
        $past(trace_line_count)})
        else $error("count register read wrong");
    a_s1_hold: assert property (seq_state == 5'h02 && match_in == '0 &&
        $past(match_in) == '0 && !ctl_wr && !sys_rst_req
        |=> seq_state == 5'h02) else $error("State1 left without a match");
    a_state_onehot: assert property ($onehot(seq_state))
        else $error("sequencer state not one-hot");

    c_arm: cover property (arm_wr);
    c_wrap: cover property (trace_line_wr && trace_line_count == 6'h3f);
    c_final: cover property (seq_state == 5'h10);
    c_slverr: cover property (pslverr);
endmodule // trace_count_properties

bind trace_count_state1_sequencer trace_count_properties #(
    .ADDR_W(ADDR_W), .MATCH_N(MATCH_N)) u_props (
    .core_clk(core_clk), .rst_b(rst_b), .sys_rst_req(sys_rst_req),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trace_line_wr(trace_line_wr), .match_in(match_in), .armed(armed),
    .seq_state(seq_state), .trace_full_flag(trace_full_flag),
    .trace_line_count(trace_line_count));
`default_nettype wire
